// *** hdl/isr_pkg.sv ***
package isr_pkg;

  // ----------------------------------------------------------------
  // Status byte field positions
  // ----------------------------------------------------------------
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;

  // ----------------------------------------------------------------
  // Event status field positions
  // ----------------------------------------------------------------
  localparam int ESR_OPC = 0;
  localparam int ESR_RQC = 1;
  localparam int ESR_QYE = 2;
  localparam int ESR_DDE = 3;
  localparam int ESR_EXE = 4;
  localparam int ESR_CME = 5;
  localparam int ESR_URQ = 6;
  localparam int ESR_PON = 7;

  // ----------------------------------------------------------------
  // Reset values and fixed masks
  // ----------------------------------------------------------------
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ESR_WRITABLE = 8'hB5;
  localparam logic [7:0] STB_USED = 8'h70;
  localparam logic [7:0] ASCII_ONE = 8'h31;

  // ----------------------------------------------------------------
  // Output queue and timing
  // ----------------------------------------------------------------
  localparam int OQ_DEPTH = 75;
  localparam int OQ_AW = 7;
  localparam int CLK_HZ = 50_000_000;
  localparam int SERIAL_CHAN_MS = 100;
  localparam int SERIAL_LOOP3_MS = 2000;
  localparam int SERIAL_CHAN_CYC = SERIAL_CHAN_MS * (CLK_HZ / 1000);
  localparam int SERIAL_LOOP3_CYC = SERIAL_LOOP3_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Decoded common commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ISR_CMD_NONE = 4'h0,
    ISR_CMD_CLS = 4'h1,
    ISR_CMD_ESE = 4'h2,
    ISR_CMD_ESE_Q = 4'h3,
    ISR_CMD_ESR_Q = 4'h4,
    ISR_CMD_OPC = 4'h5,
    ISR_CMD_OPC_Q = 4'h6,
    ISR_CMD_SRE = 4'h7,
    ISR_CMD_SRE_Q = 4'h8,
    ISR_CMD_STB_Q = 4'h9,
    ISR_CMD_WAI = 4'hA,
    ISR_CMD_RST = 4'hB
  } isr_cmd_t;

  // Command strobe with its integer argument
  typedef struct packed {
    logic valid;
    isr_cmd_t code;
    logic [7:0] arg;
  } isr_req_t;

  // Error events reported by the command parser
  typedef struct packed {
    logic exec_err;
    logic cmd_err;
  } isr_err_t;

endpackage

// *** hdl/isr_status.sv ***
`timescale 1ns/1ps
// Functional notes
// - Status byte query enqueues the byte and clears nothing.
// - Internal status byte bit six is master summary, not request service.
// - Register values travel as 8-bit integers weighted 128 down to 1.
// - Wait command stalls new commands until pending operations finish.
// - Bit four is high whenever the output queue is not empty.
// - Bit five is high when any enabled event bit is set.
// - Bit six rises when bit four or five is high and enabled.
// - On each master summary change the status byte goes to the controller.
// - Request service rise asserts service request; serial poll clears both.
// - Status byte bits seven, three, two, one, zero read zero.
// - Completion command sets event bit zero once operations finish.
// - Event bits one, three and six always read zero.
// - Query error on empty queue read or queue overflow past 75 bytes.
// - Execution error set on out of range parameter.
// - Command error set on syntax or spelling error.
// - Power-on bit set at reset, cleared by event query or clear status only.
// - Event query enqueues the event register then clears it.
// - Completion query enqueues ASCII one after operations finish.
// - Completion command never blocks; raises request through enables.
// - Serial link has no completion commands; fixed hold-off delays apply.
// - Both enable masks clear at reset.
// - Clear status clears event register, leaves output queue alone.
// - Enable masks accept any value 0 to 255.
module isr_status
  import isr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire isr_req_t req,
  output logic req_ready,
  input wire isr_err_t err,
  input wire logic op_pending,
  input wire logic serial_link,
  input wire logic chan_state_cmd,
  input wire logic loop_config_part_three_cmd,
  output logic serial_hold,
  input wire logic oq_rd,
  output logic [7:0] oq_data,
  output logic oq_valid,
  input wire logic serial_poll,
  output logic [7:0] poll_byte,
  output logic srq,
  output logic [7:0] status_summary_byte,
  output logic [7:0] standard_event_status
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISR_RUN = 3'b001,
    ISR_WAIT = 3'b010,
    ISR_HOLD = 3'b100
  } isr_state_t;

  isr_state_t state;
  logic [7:0] esr_bits;
  logic [7:0] ese_mask;
  logic [7:0] sre_mask;
  logic [7:0] oq_mem [OQ_DEPTH];
  logic [OQ_AW-1:0] oq_head;
  logic [OQ_AW-1:0] oq_tail;
  logic [OQ_AW-1:0] oq_count;
  logic opc_armed;
  logic opcq_armed;
  logic mss_prev;
  logic rqs;
  logic [31:0] hold_cnt;
  logic take;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic mav;
  logic esb;
  logic mss;
  logic opc_done;
  logic opcq_done;
  logic [7:0] esr_set;

  // Wrap a queue pointer
  function automatic logic [OQ_AW-1:0] ptr_inc(input logic [OQ_AW-1:0] p);
    ptr_inc = (p == OQ_AW'(OQ_DEPTH - 1)) ? '0 : p + OQ_AW'(1);
  endfunction

  // ----------------------------------------------------------------
  // Summary bits
  // ----------------------------------------------------------------
  // Recomputed every cycle from queue, events and masks
  assign mav = (oq_count != '0);
  assign esb = |(esr_bits & ese_mask);
  assign mss = (mav & sre_mask[STB_MAV]) | (esb & sre_mask[STB_ESB]);
  // Unused positions tied low, bit six is master summary
  assign status_summary_byte = {1'b0, mss, esb, mav, 4'h0};
  assign standard_event_status = esr_bits;

  // ----------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------
  // Commands stall while a wait or serial hold-off is in progress
  assign req_ready = (state == ISR_RUN);
  assign take = req.valid & req_ready;
  assign serial_hold = (state == ISR_HOLD);
  assign opc_done = opc_armed & ~op_pending & ~serial_link;
  assign opcq_done = opcq_armed & ~op_pending & ~serial_link;

  // Output queue push source; queries have priority over the deferred one
  always_comb begin
    push = 1'b0;
    push_data = 8'h00;
    if (take) begin
      unique case (req.code)
        ISR_CMD_STB_Q: begin
          push = 1'b1;
          push_data = status_summary_byte;
        end
        ISR_CMD_ESR_Q: begin
          push = 1'b1;
          push_data = esr_bits;
        end
        ISR_CMD_ESE_Q: begin
          push = 1'b1;
          push_data = ese_mask;
        end
        ISR_CMD_SRE_Q: begin
          push = 1'b1;
          push_data = sre_mask;
        end
        default: push = 1'b0;
      endcase
    end
    if (!push && opcq_done) begin
      push = 1'b1;
      push_data = ASCII_ONE;
    end
  end

  assign pop = oq_rd & mav;
  assign oq_valid = mav;
  assign oq_data = oq_mem[oq_head];

  // ----------------------------------------------------------------
  // Output queue
  // ----------------------------------------------------------------
  // Circular store; a push when full is dropped and flagged
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oq_head <= '0;
      oq_tail <= '0;
      oq_count <= '0;
    end else begin
      if (push && oq_count != OQ_AW'(OQ_DEPTH)) begin
        oq_mem[oq_tail] <= push_data;
        oq_tail <= ptr_inc(oq_tail);
      end
      if (pop) begin
        oq_head <= ptr_inc(oq_head);
      end
      if (push && oq_count != OQ_AW'(OQ_DEPTH) && !pop) begin
        oq_count <= oq_count + OQ_AW'(1);
      end else if (pop && !(push && oq_count != OQ_AW'(OQ_DEPTH))) begin
        oq_count <= oq_count - OQ_AW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status register
  // ----------------------------------------------------------------
  // New events this cycle
  always_comb begin
    esr_set = 8'h00;
    esr_set[ESR_OPC] = opc_done;
    esr_set[ESR_QYE] = (oq_rd & ~mav) | (push & (oq_count == OQ_AW'(OQ_DEPTH)));
    esr_set[ESR_EXE] = err.exec_err;
    esr_set[ESR_CME] = err.cmd_err;
  end

  // Clear by query or clear-status; a same-cycle event survives the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      esr_bits <= ESR_RESET;
    end else if (take && (req.code == ISR_CMD_ESR_Q || req.code == ISR_CMD_CLS)) begin
      esr_bits <= esr_set & ESR_WRITABLE;
    end else begin
      esr_bits <= (esr_bits | esr_set) & ESR_WRITABLE;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------------
  // Any byte value accepted as written
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ese_mask <= ENABLE_RESET;
      sre_mask <= ENABLE_RESET;
    end else if (take && req.code == ISR_CMD_ESE) begin
      ese_mask <= req.arg;
    end else if (take && req.code == ISR_CMD_SRE) begin
      sre_mask <= req.arg;
    end
  end

  // ----------------------------------------------------------------
  // Completion tracking
  // ----------------------------------------------------------------
  // Armed by the command, retired when nothing is pending; reset cancels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opc_armed <= 1'b0;
      opcq_armed <= 1'b0;
    end else if (take && req.code == ISR_CMD_RST) begin
      opc_armed <= 1'b0;
      opcq_armed <= 1'b0;
    end else begin
      if (take && req.code == ISR_CMD_OPC && !serial_link) begin
        opc_armed <= 1'b1;
      end else if (opc_done) begin
        opc_armed <= 1'b0;
      end
      if (take && req.code == ISR_CMD_OPC_Q && !serial_link) begin
        opcq_armed <= 1'b1;
      end else if (opcq_done && !(take && req.code inside {ISR_CMD_STB_Q, ISR_CMD_ESR_Q,
                   ISR_CMD_ESE_Q, ISR_CMD_SRE_Q})) begin
        opcq_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wait and serial hold-off sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ISR_RUN;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        ISR_RUN: begin
          if (serial_link && loop_config_part_three_cmd) begin
            state <= ISR_HOLD;
            hold_cnt <= 32'(SERIAL_LOOP3_CYC - 1);
          end else if (serial_link && chan_state_cmd) begin
            state <= ISR_HOLD;
            hold_cnt <= 32'(SERIAL_CHAN_CYC - 1);
          end else if (take && req.code == ISR_CMD_WAI && op_pending) begin
            state <= ISR_WAIT;
          end
        end
        ISR_WAIT: begin
          if (!op_pending) begin
            state <= ISR_RUN;
          end
        end
        ISR_HOLD: begin
          if (hold_cnt == '0) begin
            state <= ISR_RUN;
          end else begin
            hold_cnt <= hold_cnt - 32'd1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Service request
  // ----------------------------------------------------------------
  // Rising master summary raises request; poll clears it unless it rises again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mss_prev <= 1'b0;
      rqs <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      mss_prev <= mss;
      if (mss != mss_prev) begin
        poll_byte <= {1'b0, mss, esb, mav, 4'h0};
      end
      if (mss && !mss_prev) begin
        rqs <= 1'b1;
        poll_byte[STB_MSS] <= 1'b1;
      end else if (serial_poll) begin
        rqs <= 1'b0;
        poll_byte[STB_MSS] <= 1'b0;
      end
    end
  end

  assign srq = rqs;

endmodule

// *** bench/isr_status_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Status reporting checker
// ----------------------------------------------------------------
module isr_status_asserts
  import isr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire isr_req_t req,
  input wire logic req_ready,
  input wire isr_err_t err,
  input wire logic op_pending,
  input wire logic serial_link,
  input wire logic chan_state_cmd,
  input wire logic loop_config_part_three_cmd,
  input wire logic serial_hold,
  input wire logic oq_rd,
  input wire logic [7:0] oq_data,
  input wire logic oq_valid,
  input wire logic serial_poll,
  input wire logic [7:0] poll_byte,
  input wire logic srq,
  input wire logic [7:0] status_summary_byte,
  input wire logic [7:0] standard_event_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Command accepted this cycle
  logic taken;
  assign taken = req.valid && req_ready;

  // Poll while the master summary holds still
  sequence poll_s;
    serial_poll && $stable(status_summary_byte[6]);
  endsequence

  unused_bits_a: assert property (
    (status_summary_byte & ~STB_USED) == 8'h00) else $error("stb unused bit set");
  fixed_events_a: assert property (
    {standard_event_status[6], standard_event_status[3], standard_event_status[1]} == 3'h0)
    else $error("unsupported event bit set");
  mav_level_a: assert property (
    status_summary_byte[4] == oq_valid) else $error("mav mismatch");
  esb_idle_a: assert property (
    standard_event_status == 8'h00 |-> !status_summary_byte[5]) else $error("esb without event");
  request_rise_a: assert property (
    $rose(status_summary_byte[6]) && !serial_poll |=> srq && poll_byte[6])
    else $error("request not raised");
  poll_clear_a: assert property (
    poll_s |=> !srq && !poll_byte[6]) else $error("poll did not clear request");
  event_query_a: assert property (
    taken && req.code == ISR_CMD_ESR_Q && err == '0 && !oq_rd
    |=> oq_valid && (standard_event_status & 8'hB4) == 8'h00) else $error("event query");
  status_query_a: assert property (
    taken && req.code == ISR_CMD_STB_Q && err == '0 && !oq_rd
    |=> oq_valid && standard_event_status == $past(standard_event_status))
    else $error("status query side effect");
  wait_stall_a: assert property (
    taken && req.code == ISR_CMD_WAI && op_pending |=> !req_ready) else $error("wait no stall");
  empty_read_a: assert property (
    oq_rd && !oq_valid |=> standard_event_status[2]) else $error("empty read no error");
  pon_sticky_a: assert property (
    !standard_event_status[7] |=> !standard_event_status[7]) else $error("power bit came back");
  serial_hold_a: assert property (
    serial_link && (chan_state_cmd || loop_config_part_three_cmd) |=> serial_hold && !req_ready)
    else $error("no serial hold");
endmodule

bind isr_status isr_status_asserts isr_status_asserts_i (.mclk, .rst_n, .req, .req_ready,
  .err, .op_pending, .serial_link, .chan_state_cmd, .loop_config_part_three_cmd, .serial_hold,
  .oq_rd, .oq_data, .oq_valid, .serial_poll, .poll_byte, .srq, .status_summary_byte,
  .standard_event_status);

// *** bench/isr_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus controller answering service requests by serial poll
// ----------------------------------------------------------------
module isr_host #(
  parameter int POLL_DLY = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic srq,
  output logic serial_poll
);
  int cnt = 0;

  // Poll a few cycles after the request line rises
  always @(negedge mclk) begin
    serial_poll <= 1'b0;
    if (!rst_n || !srq) begin
      cnt <= 0;
    end else if (cnt == POLL_DLY) begin
      serial_poll <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import isr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  isr_req_t req = '0;
  isr_err_t err = '0;
  logic op_pending = 1'b0;
  logic serial_link = 1'b0;
  logic chan_state_cmd = 1'b0;
  logic loop_config_part_three_cmd = 1'b0;
  logic oq_rd = 1'b0;
  logic req_ready, serial_hold, oq_valid, serial_poll, srq;
  logic [7:0] oq_data, poll_byte, status_summary_byte, standard_event_status;
  int n_fail = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // Design and controller model
  // ----------------------------------------------------------------
  always #10 mclk = ~mclk;

  isr_status isr_status_i (.mclk, .rst_n, .req, .req_ready, .err, .op_pending, .serial_link,
    .chan_state_cmd, .loop_config_part_three_cmd, .serial_hold, .oq_rd, .oq_data, .oq_valid,
    .serial_poll, .poll_byte, .srq, .status_summary_byte, .standard_event_status);

  isr_host isr_host_i (.mclk, .rst_n, .srq, .serial_poll);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Hold a command until it is taken
  task automatic cmd(input isr_cmd_t code, input logic [7:0] arg);
    int n;
    n = 0;
    @(negedge mclk);
    req <= {1'b1, code, arg};
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(n < 500), 8'h01);
    @(negedge mclk);
    req <= '0;
  endtask

  // Pop one byte and compare it
  task automatic pop(input logic [7:0] exp);
    @(negedge mclk);
    chk(8'(oq_valid), 8'h01);
    chk(oq_data, exp);
    oq_rd <= 1'b1;
    @(negedge mclk);
    oq_rd <= 1'b0;
  endtask

  // Wait for the request line to reach a level
  task automatic wait_srq(input logic lvl);
    int n;
    for (n = 0; n < 50 && srq !== lvl; n++) @(negedge mclk);
  endtask

  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(standard_event_status, ESR_RESET);
    chk(status_summary_byte, 8'h00);
    cmd(ISR_CMD_ESE_Q, 8'h00);
    pop(ENABLE_RESET);
    cmd(ISR_CMD_SRE_Q, 8'h00);
    pop(ENABLE_RESET);
    cmd(ISR_CMD_ESR_Q, 8'h00);
    pop(8'h80);
    chk(standard_event_status, 8'h00);
    cmd(ISR_CMD_STB_Q, 8'h00);
    cmd(ISR_CMD_STB_Q, 8'h00);
    pop(8'h00);
    pop(8'h10);
    @(negedge mclk);
    oq_rd <= 1'b1;
    @(negedge mclk);
    oq_rd <= 1'b0;
    chk(standard_event_status, 8'h04);
    err <= 2'b11;
    @(negedge mclk);
    err <= 2'b00;
    @(negedge mclk);
    chk(standard_event_status, 8'h34);
    cmd(ISR_CMD_ESE, 8'h34);
    chk(status_summary_byte, 8'h20);
    cmd(ISR_CMD_SRE, 8'h20);
    wait_srq(1'b1);
    chk(poll_byte, 8'h60);
    wait_srq(1'b0);
    chk(poll_byte & 8'h40, 8'h00);
    chk(status_summary_byte, 8'h60);
    cmd(ISR_CMD_CLS, 8'h00);
    chk(status_summary_byte, 8'h00);
    op_pending <= 1'b1;
    cmd(ISR_CMD_OPC, 8'h00);
    cmd(ISR_CMD_OPC_Q, 8'h00);
    chk(8'(req_ready), 8'h01);
    chk(standard_event_status, 8'h00);
    op_pending <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(standard_event_status, 8'h01);
    pop(ASCII_ONE);
    cmd(ISR_CMD_ESR_Q, 8'h00);
    pop(8'h01);
    op_pending <= 1'b1;
    cmd(ISR_CMD_WAI, 8'h00);
    repeat (4) @(negedge mclk);
    chk(8'(req_ready), 8'h00);
    op_pending <= 1'b0;
    cmd(ISR_CMD_STB_Q, 8'h00);
    pop(8'h00);
    // Reset command cancels an armed completion
    op_pending <= 1'b1;
    cmd(ISR_CMD_OPC, 8'h00);
    cmd(ISR_CMD_RST, 8'h00);
    op_pending <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(standard_event_status, 8'h00);
    for (int i = 0; i <= OQ_DEPTH; i++) cmd(ISR_CMD_ESE_Q, 8'h00);
    chk(standard_event_status, 8'h04);
    for (int i = 0; i < OQ_DEPTH; i++) pop(8'h34);
    chk(8'(oq_valid), 8'h00);
    serial_link <= 1'b1;
    op_pending <= 1'b1;
    cmd(ISR_CMD_OPC_Q, 8'h00);
    op_pending <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(8'(oq_valid), 8'h00);
    loop_config_part_three_cmd <= 1'b1;
    @(negedge mclk);
    loop_config_part_three_cmd <= 1'b0;
    chk(8'({serial_hold, req_ready}), 8'h02);
    rst_n <= 1'b0;
    repeat (2) @(negedge mclk);
    rst_n <= 1'b1;
    chan_state_cmd <= 1'b1;
    @(negedge mclk);
    chan_state_cmd <= 1'b0;
    chk(8'({serial_hold, req_ready}), 8'h02);
    chk(standard_event_status, ESR_RESET);
    tally_and_finish();
  end

  // Cut a hung run short
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end
endmodule
